// ---- design/edpc_params.svh ----
// Constants for the energy detect power control block of one port.
// Assumes a 250 MHz device clock and an APB slave with 32-bit data.
// What this block does
// - Power management acts only while enable bit 15 is set; reset from strap.
// - Bit 14 set (reset 1): power up when data count reaches data threshold.
// - Bit 13 set (reset 1): power down when no line energy is detected.
// - Writing 1 to bit 12 toggles power state; bit clears itself.
// - Manual change ignores both thresholds and the inactivity timer.
// - With bursting enabled (bit 11 reset 0) send 4 detect pulses per power-up that starts with no burst running.
// - With burst disable set, send one detect pulse per power-up that starts with no pulse running.
// - Read-only bit 10 shows 1 powered up, 0 powered down.
// - Bit 9 flags error threshold met; no action; cleared on read.
// - Bit 8 set when data count reaches threshold; cleared on read.
// - Bits 7:4 error threshold, reset 0001, averages line noise.
// - Bits 3:0 data threshold, reset 0001.
// - Event counters reset after about 2 seconds without data events.
// - Register sits at management address 1Dh.
`ifndef EDPC_PARAMS_SVH
`define EDPC_PARAMS_SVH

`define EDPC_ADDR_EDCS        32'h0000_0074
`define EDPC_MGMT_ADDR        5'h1d
`define EDPC_BIT_ENABLE       15
`define EDPC_BIT_AUTO_UP      14
`define EDPC_BIT_AUTO_DOWN    13
`define EDPC_BIT_MANUAL       12
`define EDPC_BIT_BURST_DIS    11
`define EDPC_BIT_PWR_STATE    10
`define EDPC_BIT_ERR_MET      9
`define EDPC_BIT_DATA_MET     8
`define EDPC_ERR_THR_LSB      4
`define EDPC_DATA_THR_LSB     0
`define EDPC_RST_AUTO_UP      1'b1
`define EDPC_RST_AUTO_DOWN    1'b1
`define EDPC_RST_BURST_DIS    1'b0
`define EDPC_RST_ERR_THR      4'h1
`define EDPC_RST_DATA_THR     4'h1
`define EDPC_CLK_MHZ          250
`define EDPC_IDLE_MS          2000
`define EDPC_BURST_PULSES     3'h4
`define EDPC_PULSE_HIGH_CYC   8'h19
`define EDPC_PULSE_GAP_CYC    8'hfa

`endif

// ---- design/edpc_pkg.sv ----
// Types shared by the energy detect power control files.
// Assumes the constants header is compiled alongside.
package edpc_pkg;
  typedef enum logic [1:0] {
    EDPC_P_IDLE,
    EDPC_P_HIGH,
    EDPC_P_GAP
  } edpc_pulse_e;
endpackage : edpc_pkg

// ---- design/edpc_pulse_gen.sv ----
// Detect pulse generator: sends one or four pulses per start request taken while idle.
// Assumes start is a one-cycle pulse on the device clock.
`timescale 1ns/1ps
`include "edpc_params.svh"
module edpc_pulse_gen (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  input  wire logic single_in,
  output logic      pulse_out,
  output logic      busy_out
);
  edpc_pkg::edpc_pulse_e state;
  logic [2:0]            left;
  logic [7:0]            cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse sequencer; a new start while busy is dropped, at most one burst at a time
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state <= edpc_pkg::EDPC_P_IDLE;
      left  <= 3'h0;
      cnt   <= 8'h00;
    end else begin
      unique case (state)
        edpc_pkg::EDPC_P_IDLE: begin
          if (start_in) begin
            left  <= single_in ? 3'h1 : `EDPC_BURST_PULSES;
            cnt   <= 8'h00;
            state <= edpc_pkg::EDPC_P_HIGH;
          end
        end
        edpc_pkg::EDPC_P_HIGH: begin
          if (cnt == `EDPC_PULSE_HIGH_CYC - 8'h01) begin
            cnt   <= 8'h00;
            left  <= left - 3'h1;
            state <= edpc_pkg::EDPC_P_GAP;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        edpc_pkg::EDPC_P_GAP: begin
          if (left == 3'h0) begin
            state <= edpc_pkg::EDPC_P_IDLE;
          end else if (cnt == `EDPC_PULSE_GAP_CYC - 8'h01) begin
            cnt   <= 8'h00;
            state <= edpc_pkg::EDPC_P_HIGH;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
      endcase
    end
  end

  // Output pulse registered so it is glitch free toward the line driver
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state == edpc_pkg::EDPC_P_HIGH);
    end
  end

  assign busy_out = (state != edpc_pkg::EDPC_P_IDLE);
endmodule : edpc_pulse_gen

// ---- design/edpc_top.sv ----
// Energy detect power control for one port with its APB control register.
// Assumes line events arrive as one-cycle pulses synchronous to ref_clk_in.
`timescale 1ns/1ps
`include "edpc_params.svh"
module edpc_top #(
  parameter int unsigned IDLE_CYCLES = `EDPC_CLK_MHZ * 1000 * `EDPC_IDLE_MS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        enable_strap_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        data_event_in,
  input  wire logic        error_event_in,
  input  wire logic        energy_present_in,
  output logic             power_up_out,
  output logic             detect_pulse_out
);
  logic        edet_enable;
  logic        auto_power_up;
  logic        auto_power_down;
  logic        pulse_burst_disable;
  logic        power_state_flag;
  logic        error_threshold_met;
  logic        data_threshold_met;
  logic [3:0]  error_threshold;
  logic [3:0]  data_threshold;
  logic [3:0]  data_count;
  logic [3:0]  error_count;
  logic [31:0] idle_count;
  logic        strap_pending;
  logic        access;
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic        manual_power_toggle;
  logic        idle_expired;
  logic [3:0]  next_data_count;
  logic [3:0]  next_error_count;
  logic        data_reach;
  logic        error_reach;
  logic        auto_up;
  logic        auto_down;
  logic        go_up;
  logic        go_down;
  logic        pulse_busy;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, unmapped addresses answer with pslverr
  assign access     = psel_in && penable_in;
  assign hit        = (paddr_in == `EDPC_ADDR_EDCS);
  assign wr_hit     = access && pwrite_in && hit;
  assign rd_hit     = access && !pwrite_in && hit;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !hit;

  // Manual toggle is a write-one pulse; the bit never holds a 1
  assign manual_power_toggle = wr_hit && pstrb_in[1] && pwdata_in[`EDPC_BIT_MANUAL];

  ////////////////////////////////////////////////////////////////////////////
  // Enable is caught from the strap on the first clock after reset release
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      strap_pending <= 1'b1;
      edet_enable   <= 1'b0;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      edet_enable   <= enable_strap_in;
    end else if (wr_hit && pstrb_in[1]) begin
      edet_enable   <= pwdata_in[`EDPC_BIT_ENABLE];
    end
  end

  // Control fields in the low and high byte lanes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      auto_power_up       <= `EDPC_RST_AUTO_UP;
      auto_power_down     <= `EDPC_RST_AUTO_DOWN;
      pulse_burst_disable <= `EDPC_RST_BURST_DIS;
      error_threshold     <= `EDPC_RST_ERR_THR;
      data_threshold      <= `EDPC_RST_DATA_THR;
    end else if (wr_hit) begin
      if (pstrb_in[1]) begin
        auto_power_up       <= pwdata_in[`EDPC_BIT_AUTO_UP];
        auto_power_down     <= pwdata_in[`EDPC_BIT_AUTO_DOWN];
        pulse_burst_disable <= pwdata_in[`EDPC_BIT_BURST_DIS];
      end
      if (pstrb_in[0]) begin
        error_threshold <= pwdata_in[`EDPC_ERR_THR_LSB +: 4];
        data_threshold  <= pwdata_in[`EDPC_DATA_THR_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inactivity timer: restarts on every data event
  assign idle_expired = (idle_count >= IDLE_CYCLES - 1);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      idle_count <= 32'h0000_0000;
    end else if (data_event_in || idle_expired) begin
      idle_count <= 32'h0000_0000;
    end else begin
      idle_count <= idle_count + 32'h0000_0001;
    end
  end

  // Saturating event counts with the compare done on the incremented value
  always_comb begin
    next_data_count  = data_count;
    next_error_count = error_count;
    if (data_event_in && data_count != 4'hf) begin
      next_data_count = data_count + 4'h1;
    end
    if (error_event_in && error_count != 4'hf) begin
      next_error_count = error_count + 4'h1;
    end
  end

  // A zero threshold never fires, otherwise every event would trigger
  assign data_reach  = data_event_in && (data_threshold != 4'h0) &&
                       (next_data_count >= data_threshold);
  assign error_reach = error_event_in && (error_threshold != 4'h0) &&
                       (next_error_count >= error_threshold);

  // Counters restart after a long quiet spell or once a threshold acts
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      data_count  <= 4'h0;
      error_count <= 4'h0;
    end else if (idle_expired && !data_event_in) begin
      data_count  <= 4'h0;
      error_count <= 4'h0;
    end else begin
      data_count  <= data_reach ? 4'h0 : next_data_count;
      error_count <= error_reach ? 4'h0 : next_error_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: set in the reaching cycle, set wins over read clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      data_threshold_met  <= 1'b0;
      error_threshold_met <= 1'b0;
    end else begin
      if (data_reach) begin
        data_threshold_met <= 1'b1;
      end else if (rd_hit) begin
        data_threshold_met <= 1'b0;
      end
      if (error_reach) begin
        error_threshold_met <= 1'b1;
      end else if (rd_hit) begin
        error_threshold_met <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine; error threshold deliberately drives nothing here
  assign auto_up   = auto_power_up && data_reach && !power_state_flag;
  assign auto_down = auto_power_down && !energy_present_in && power_state_flag;
  assign go_up     = edet_enable && !power_state_flag &&
                     (manual_power_toggle || auto_up);
  assign go_down   = edet_enable && power_state_flag &&
                     (manual_power_toggle || auto_down);

  // Starts powered up so a port with the feature off behaves normally
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      power_state_flag <= 1'b1;
    end else if (!edet_enable) begin
      power_state_flag <= 1'b1;
    end else if (go_up) begin
      power_state_flag <= 1'b1;
    end else if (go_down) begin
      power_state_flag <= 1'b0;
    end
  end

  assign power_up_out = power_state_flag;

  // Burst or single detect pulse on each go_up that finds the generator idle
  edpc_pulse_gen edpc_pulse_gen_inst (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .start_in   (go_up),
    .single_in  (pulse_burst_disable),
    .pulse_out  (detect_pulse_out),
    .busy_out   (pulse_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data registered; sampled in setup so it is valid in the access cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in && paddr_in == `EDPC_ADDR_EDCS) begin
      prdata_out <= {16'h0000,
                     edet_enable, auto_power_up, auto_power_down, 1'b0,
                     pulse_burst_disable, power_state_flag,
                     error_threshold_met, data_threshold_met,
                     error_threshold, data_threshold};
    end else if (!psel_in) begin
      prdata_out <= 32'h0000_0000;
    end
  end
endmodule : edpc_top

// ---- verification/edpc_line_partner.sv ----
// Cable partner model: line energy level and single-cycle event pulses.
// Assumes bench requests are one-cycle pulses on the device clock.
`timescale 1ns/1ps
module edpc_line_partner (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic send_data_in,
  input  wire logic send_err_in,
  input  wire logic line_on_in,
  output logic      data_event_out,
  output logic      error_event_out,
  output logic      energy_present_out
);
  // Events leave one edge after the request and last as long as the request
  always_ff @(posedge ref_clk_in) begin
    data_event_out  <= rst_n_in && send_data_in;
    error_event_out <= rst_n_in && send_err_in;
  end
  // Energy can be dropped so that auto power-down is provoked
  always_ff @(posedge ref_clk_in) begin
    energy_present_out <= line_on_in;
  end
endmodule : edpc_line_partner

// ---- verification/edpc_top_monitor.sv ----
// Checker for the energy detect power control top, attached by bind.
// Assumes one clock domain and the zero-wait APB answer of the design.
`timescale 1ns/1ps
module edpc_top_monitor #(
  parameter int unsigned IDLE_CYCLES = 200
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        power_up_out,
  input wire logic        detect_pulse_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Access cycle to our word; everything else is refused
  wire acc = psel_in && penable_in;
  wire hit = acc && (paddr_in == 32'h0000_0074);
  wire rd  = hit && !pwrite_in;
  // Manual toggle while enabled and up must take the port down soon after
  wire tog = hit && pwrite_in && pstrb_in[1] && pwdata_in[15] && pwdata_in[12];
  ////////////////////////////////////////////////////////////////////
  property p_ready; acc |-> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_slverr; acc && !hit |-> pslverr_out; endproperty
  a_slverr: assert property (p_slverr) else $error("no slverr off map");
  property p_noerr; hit |-> !pslverr_out; endproperty
  a_noerr: assert property (p_noerr) else $error("slverr on own word");
  property p_upper; rd |-> prdata_out[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_man0; rd |-> !prdata_out[12]; endproperty
  a_man0: assert property (p_man0) else $error("toggle bit reads one");
  property p_state; rd |-> prdata_out[10] == $past(power_up_out); endproperty
  a_state: assert property (p_state) else $error("state bit mismatch");
  property p_width; $rose(detect_pulse_out) |-> ##24 detect_pulse_out ##1 !detect_pulse_out;
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_gap; $fell(detect_pulse_out) |-> ##249 !detect_pulse_out; endproperty
  a_gap: assert property (p_gap) else $error("pulse gap short");
  property p_toggle; tog && power_up_out |-> ##[1:3] !power_up_out; endproperty
  a_toggle: assert property (p_toggle) else $error("manual toggle ignored");
  // Main scenarios reached
  c_pulse: cover property ($rose(detect_pulse_out));
  c_down: cover property ($fell(power_up_out));
  c_refuse: cover property (acc && pslverr_out);
endmodule : edpc_top_monitor

bind edpc_top edpc_top_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) edpc_top_monitor_inst (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .power_up_out(power_up_out),
  .detect_pulse_out(detect_pulse_out));

// ---- verification/edpc_top_tb.sv ----
// Self-checking bench for the energy detect power control top.
// Assumes design files and the line partner model are compiled first.
`timescale 1ns/1ps
module edpc_top_tb;
  logic        clk, rst_n, psel, pen, pwr, sd, se, lon, pready, perr, de, ee, ep, pup, dp, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          failures, checked, n;
  // Short idle span keeps the inactivity reset testable
  edpc_top #(.IDLE_CYCLES(200)) edpc_top_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n), .enable_strap_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .data_event_in(de), .error_event_in(ee), .energy_present_in(ep),
    .power_up_out(pup), .detect_pulse_out(dp));
  edpc_line_partner edpc_line_partner_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n), .send_data_in(sd), .send_err_in(se),
    .line_on_in(lon), .data_event_out(de), .error_event_out(ee), .energy_present_out(ep));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high
  // No wait limit of its own: only the watchdog ends a hung transfer
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [31:0] e);
    apb(1'b0, 32'h0000_0074, 32'h0);
    chk("register", e, rd);
  endtask : rdc
  task automatic ev(input logic err);
    @(posedge clk);
    if (err) se <= 1'b1;
    else sd <= 1'b1;
    @(posedge clk);
    se <= 1'b0;
    sd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev
  task automatic pw(input logic e);
    repeat (4) @(posedge clk);
    chk("power", {31'h0, e}, {31'h0, pup});
  endtask : pw
  // Counts detect pulse starts over a span longer than a full burst
  task automatic pulses();
    logic prev;
    n = 0;
    // Starts from low so a pulse already under way when called still counts
    prev = 1'b0;
    repeat (1200) begin
      @(posedge clk);
      if (dp && !prev) n++;
      prev = dp;
    end
  endtask : pulses
  ////////////////////////////////////////////////////////////////////
  // Auto-negotiation and crossover live elsewhere; the bench never touches them
  task automatic t_reset();
    rdc(32'h0000_e411);
  endtask : t_reset
  task automatic t_unmapped();
    apb(1'b1, 32'h0000_0070, 32'h0);
    chk("slverr", 1, er);
    apb(1'b0, 32'h0000_0070, 32'h0);
    chk("refused data", 0, rd);
    rdc(32'h0000_e411);
    chk("slverr", 0, er);
  endtask : t_unmapped
  task automatic t_down();
    lon <= 1'b0;
    pw(1'b0);
    rdc(32'h0000_e011);
    lon <= 1'b1;
  endtask : t_down
  task automatic t_up();
    apb(1'b1, 32'h0000_0074, 32'h0000_e013);
    ev(1'b0);
    ev(1'b0);
    pw(1'b0);
    ev(1'b0);
    pulses();
    chk("power", 1, {31'h0, pup});
    chk("pulse count", 4, n);
    rdc(32'h0000_e513);
    rdc(32'h0000_e413);
  endtask : t_up
  task automatic t_err();
    apb(1'b1, 32'h0000_0074, 32'h0000_e423);
    // Data event restarts the quiet timer so no counter reset falls between errors
    ev(1'b0);
    ev(1'b1);
    rdc(32'h0000_e423);
    ev(1'b1);
    rdc(32'h0000_e623);
    pw(1'b1);
    rdc(32'h0000_e423);
  endtask : t_err
  task automatic t_manual();
    rdc(32'h0000_e423);
    apb(1'b1, 32'h0000_0074, 32'h0000_f423);
    pw(1'b0);
    rdc(32'h0000_e023);
  endtask : t_manual
  task automatic t_idle();
    apb(1'b1, 32'h0000_0074, 32'h0000_e823);
    // Let the quiet timer clear the data event left over from the error scenario
    repeat (210) @(posedge clk);
    ev(1'b0);
    ev(1'b0);
    repeat (300) @(posedge clk);
    ev(1'b0);
    ev(1'b0);
    pw(1'b0);
    ev(1'b0);
    pulses();
    chk("power", 1, {31'h0, pup});
    chk("pulse count", 1, n);
  endtask : t_idle
  task automatic t_off();
    apb(1'b1, 32'h0000_0074, 32'h0000_f823);
    pw(1'b0);
    apb(1'b1, 32'h0000_0074, 32'h0000_6823);
    pw(1'b1);
    apb(1'b1, 32'h0000_0074, 32'h0000_7823);
    pw(1'b1);
  endtask : t_off
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pstrb = 4'h3; sd = 1'b0; se = 1'b0; lon = 1'b1; failures = 0; checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_unmapped();
    t_down();
    t_up();
    t_err();
    t_manual();
    t_idle();
    t_off();
    stop_test();
  end
endmodule : edpc_top_tb
